// ### rtl/tx_descriptor_legacy16_pkg.sv
package tx_descriptor_legacy16_pkg;

   // Memory side and format select widths
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned FORMAT_W = 8;

   // Byte offsets of the four descriptor words
   localparam logic [ADDR_W-1:0] OFS_ADDR_LO = 24'h000000;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 24'h000002;
   localparam logic [ADDR_W-1:0] OFS_LENGTH = 24'h000004;
   localparam logic [ADDR_W-1:0] OFS_SPARE = 24'h000006;

   // Bit positions in the offset-2 word
   localparam int unsigned OWN_BIT = 15;
   localparam int unsigned SPARE_BIT = 14;
   localparam int unsigned APPEND_CHECKSUM_BIT = 13;
   localparam int unsigned FRAME_IRQ_SELECT_BIT = 12;
   localparam int unsigned SPARE_HI_BIT = 11;
   localparam int unsigned SPARE_LO_BIT = 10;
   localparam int unsigned FIRST_BUFFER_BIT = 9;
   localparam int unsigned LAST_BUFFER_BIT = 8;
   localparam int unsigned ADDR_HI_MSB = 7;
   localparam int unsigned ADDR_HI_LSB = 0;

   // Descriptor format select value of the legacy 16-bit layout
   localparam logic [FORMAT_W-1:0] FORMAT_LEGACY16 = 8'h00;

   // Data FIFO: one byte plus an end-of-frame marker
   localparam int unsigned FIFO_WIDTH = 9;
   localparam int unsigned FIFO_DEPTH = 32;

   // Reset values and the one-byte remaining length
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] LEN_ONE = 16'h0001;

   typedef enum logic [7:0] {
      ST_IDLE    = 8'h01,
      ST_FLAGS   = 8'h02,
      ST_ADDR    = 8'h04,
      ST_LEN     = 8'h08,
      ST_FETCH   = 8'h10,
      ST_PUSH    = 8'h20,
      ST_RETURN  = 8'h40,
      ST_ADVANCE = 8'h80
   } seq_state_t;

endpackage

// ### rtl/tx_descriptor_legacy16.sv
// Summary of operation
// - With the format select at zero, descriptors are decoded as the legacy four-word 16-bit layout.
// - The 24-bit buffer address is word 0 for bits 15:0 and the low byte of word 2 for bits 23:16.
// - Bit 15 of word 2 is ownership: 0 means the host holds the descriptor, 1 means the device does.
// - After the last buffer byte is queued in the FIFO the device clears ownership, returning the descriptor.
// - Neither party alters a descriptor after handing it over.
// - Bit 13 of word 2 in any buffer of a frame forces checksum generation over the global disable; when clear in all, the disable decides.
// - While automatic padding is on, the per-descriptor checksum flag is ignored.
// - The device never changes the checksum, first, last or length fields.
// - With the last-frame gate on, the done flag is raised only for a frame ending with select and last set.
// - With the last-frame gate off, the per-descriptor select flag is ignored.
// - Outside a frame, device-held descriptors lacking the first flag are skipped until one with owner and first is found.
// - Bit 8 of word 2 marks the last buffer; first plus last means a single unchained buffer.
// - Word 4 holds the two's complement of the length, and exactly that many bytes are sent.
// - Any buffer length is accepted, with no minimum size.

module tx_byte_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 32
) (
   input wire logic mclk_i, // Clock
   input wire logic nrst_i, // Async reset, active low
   input wire logic ce_i, // Clock enable
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Space available
   output logic [WIDTH-1:0] out_data_o, // Head entry
   output logic out_valid_o, // Head entry valid
   input wire logic out_ready_i // Consumer takes head
);
   localparam int unsigned PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W:0] CNT_ONE = (PTR_W+1)'(1);
   localparam logic [PTR_W:0] CNT_LAST = (PTR_W+1)'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0] count_q;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_ptr_q];

   always_ff @(posedge mclk_i) begin
      if (ce_i && push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else if (ce_i) begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end

   // Flags are registered so both sides see flop outputs
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_q <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else if (ce_i) begin
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
            in_ready_o <= (count_q != CNT_LAST);
            out_valid_o <= 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
            in_ready_o <= 1'b1;
            out_valid_o <= (count_q != CNT_ONE);
         end else begin
            in_ready_o <= (count_q != CNT_FULL);
            out_valid_o <= (count_q != '0);
         end
      end
   end
endmodule

module tx_descriptor_legacy16
   import tx_descriptor_legacy16_pkg::*;
(
   input wire logic mclk_i, // Bus clock, 100 MHz
   input wire logic nrst_i, // Async reset, active low
   input wire logic ce_i, // Clock enable, freezes all state when low
   input wire logic enable_i, // Transmit descriptor processing on
   input wire logic poll_i, // Pulse: look at current descriptor
   input wire logic [FORMAT_W-1:0] descriptor_format_select_i, // Software structure style
   input wire logic disable_tx_checksum_i, // Global checksum disable
   input wire logic auto_pad_transmit_i, // Automatic pad control
   input wire logic last_frame_irq_gate_i, // Last-frame interrupt gate
   input wire logic [ADDR_W-1:0] desc_addr_i, // Current descriptor byte address
   output logic desc_next_o, // Pulse: advance to next descriptor
   output logic mem_req_o, // Memory word request
   output logic mem_we_o, // Memory write
   output logic [ADDR_W-1:0] mem_addr_o, // Memory byte address
   output logic [WORD_W-1:0] mem_wdata_o, // Memory write data
   input wire logic [WORD_W-1:0] mem_rdata_i, // Memory read data
   input wire logic mem_ack_i, // Pulse: memory access done
   output logic [BYTE_W-1:0] tx_data_o, // Frame byte toward the MAC
   output logic tx_last_o, // Last byte of frame
   output logic tx_valid_o, // Frame byte valid
   input wire logic tx_ready_i, // MAC takes the byte
   output logic fcs_enable_o, // Checksum append for the frame just queued
   output logic frame_done_o, // Pulse: whole frame queued
   output logic tx_done_irq_flag_o, // Pulse: set transmit-done flag
   output logic skip_o, // Pulse: descriptor skipped
   output logic busy_o, // Sequencer not idle
   output logic [ADDR_W-1:0] tx_buffer_pointer_o // Current buffer byte pointer
);
   seq_state_t state_q;
   logic go_q;
   logic in_frame_q;
   logic append_seen_q;
   logic [WORD_W-1:0] flags_q;
   logic [ADDR_W-1:0] ptr_q;
   logic [WORD_W-1:0] remain_q;
   logic [BYTE_W-1:0] byte_q;
   logic legacy_fmt;
   logic flag_own;
   logic flag_first;
   logic flag_last;
   logic flag_append;
   logic flag_irq_sel;
   logic fifo_in_ready;
   logic fifo_in_valid;
   logic [FIFO_WIDTH-1:0] fifo_in_data;
   logic [FIFO_WIDTH-1:0] fifo_out_data;
   logic fifo_out_valid;
   logic byte_taken;
   logic ret_done;
   logic [WORD_W-1:0] rd_len;

   assign legacy_fmt = (descriptor_format_select_i == FORMAT_LEGACY16);
   // Only the named fields of word 2 are decoded; spare bits and word 6 never steer anything
   assign flag_own = flags_q[OWN_BIT];
   assign flag_first = flags_q[FIRST_BUFFER_BIT];
   assign flag_last = flags_q[LAST_BUFFER_BIT];
   assign flag_append = flags_q[APPEND_CHECKSUM_BIT];
   assign flag_irq_sel = flags_q[FRAME_IRQ_SELECT_BIT];
   assign rd_len = WORD_RESET - mem_rdata_i;

   assign fifo_in_valid = (state_q == ST_PUSH);
   assign fifo_in_data = {flag_last && (remain_q == LEN_ONE), byte_q};
   assign byte_taken = fifo_in_valid && fifo_in_ready;
   assign ret_done = (state_q == ST_RETURN) && mem_ack_i;

   // Poll request; reloaded after each advance so chained buffers go on without a poll
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         go_q <= 1'b0;
      end else if (ce_i) begin
         if (poll_i || state_q == ST_ADVANCE) begin
            go_q <= 1'b1;
         end else if (state_q == ST_IDLE && enable_i && legacy_fmt) begin
            go_q <= 1'b0;
         end
      end
   end

   // Descriptor sequencer with its memory command
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_IDLE;
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= ADDR_RESET;
         mem_wdata_o <= WORD_RESET;
         flags_q <= WORD_RESET;
         ptr_q <= ADDR_RESET;
         remain_q <= WORD_RESET;
         byte_q <= '0;
      end else if (ce_i) begin
         unique case (state_q)
            ST_IDLE: begin
               if (enable_i && legacy_fmt && go_q) begin
                  mem_req_o <= 1'b1;
                  mem_we_o <= 1'b0;
                  mem_addr_o <= desc_addr_i + OFS_FLAGS;
                  state_q <= ST_FLAGS;
               end
            end
            ST_FLAGS: begin
               if (mem_ack_i) begin
                  flags_q <= mem_rdata_i;
                  if (!mem_rdata_i[OWN_BIT]) begin
                     mem_req_o <= 1'b0;
                     state_q <= ST_IDLE;
                  end else if (!in_frame_q && !mem_rdata_i[FIRST_BUFFER_BIT]) begin
                     mem_req_o <= 1'b0;
                     state_q <= ST_ADVANCE;
                  end else begin
                     mem_addr_o <= desc_addr_i + OFS_ADDR_LO;
                     state_q <= ST_ADDR;
                  end
               end
            end
            ST_ADDR: begin
               if (mem_ack_i) begin
                  ptr_q <= {flags_q[ADDR_HI_MSB:ADDR_HI_LSB], mem_rdata_i};
                  mem_addr_o <= desc_addr_i + OFS_LENGTH;
                  state_q <= ST_LEN;
               end
            end
            ST_LEN: begin
               if (mem_ack_i) begin
                  remain_q <= rd_len;
                  if (rd_len == WORD_RESET) begin
                     mem_we_o <= 1'b1;
                     mem_addr_o <= desc_addr_i + OFS_FLAGS;
                     mem_wdata_o <= flags_q & ~(WORD_W'(1) << OWN_BIT);
                     state_q <= ST_RETURN;
                  end else begin
                     mem_addr_o <= ptr_q;
                     state_q <= ST_FETCH;
                  end
               end
            end
            ST_FETCH: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  byte_q <= ptr_q[0] ? mem_rdata_i[WORD_W-1:BYTE_W] : mem_rdata_i[BYTE_W-1:0];
                  state_q <= ST_PUSH;
               end
            end
            ST_PUSH: begin
               if (byte_taken) begin
                  ptr_q <= ptr_q + 1'b1;
                  remain_q <= remain_q - 1'b1;
                  mem_req_o <= 1'b1;
                  if (remain_q == LEN_ONE) begin
                     // Only ownership changes; every host field is written back as read
                     mem_we_o <= 1'b1;
                     mem_addr_o <= desc_addr_i + OFS_FLAGS;
                     mem_wdata_o <= flags_q & ~(WORD_W'(1) << OWN_BIT);
                     state_q <= ST_RETURN;
                  end else begin
                     mem_addr_o <= ptr_q + 1'b1;
                     state_q <= ST_FETCH;
                  end
               end
            end
            ST_RETURN: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  mem_we_o <= 1'b0;
                  state_q <= ST_ADVANCE;
               end
            end
            ST_ADVANCE: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Frame chaining and checksum decision
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_frame_q <= 1'b0;
         append_seen_q <= 1'b0;
         fcs_enable_o <= 1'b0;
      end else if (ce_i && ret_done) begin
         if (flag_last) begin
            in_frame_q <= 1'b0;
            append_seen_q <= 1'b0;
            if (auto_pad_transmit_i) begin
               fcs_enable_o <= !disable_tx_checksum_i;
            end else begin
               fcs_enable_o <= append_seen_q || flag_append || !disable_tx_checksum_i;
            end
         end else begin
            in_frame_q <= 1'b1;
            append_seen_q <= append_seen_q || flag_append;
         end
      end
   end

   // Event pulses; a frame is complete once the ownership write-back of its last descriptor is acknowledged
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         frame_done_o <= 1'b0;
         tx_done_irq_flag_o <= 1'b0;
         desc_next_o <= 1'b0;
         skip_o <= 1'b0;
      end else if (ce_i) begin
         frame_done_o <= ret_done && flag_last;
         if (last_frame_irq_gate_i) begin
            tx_done_irq_flag_o <= ret_done && flag_last && flag_irq_sel;
         end else begin
            tx_done_irq_flag_o <= ret_done && flag_last;
         end
         desc_next_o <= (state_q == ST_FLAGS) && mem_ack_i && mem_rdata_i[OWN_BIT]
                        && !in_frame_q && !mem_rdata_i[FIRST_BUFFER_BIT]
                        || ret_done;
         skip_o <= (state_q == ST_FLAGS) && mem_ack_i && mem_rdata_i[OWN_BIT]
                   && !in_frame_q && !mem_rdata_i[FIRST_BUFFER_BIT];
      end
   end

   // Status
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
         tx_buffer_pointer_o <= ADDR_RESET;
      end else if (ce_i) begin
         busy_o <= (state_q != ST_IDLE);
         tx_buffer_pointer_o <= ptr_q;
      end
   end

   tx_byte_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .in_data_i(fifo_in_data),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(tx_ready_i)
   );

   assign tx_data_o = fifo_out_data[BYTE_W-1:0];
   assign tx_last_o = fifo_out_data[BYTE_W];
   assign tx_valid_o = fifo_out_valid;
endmodule

// ### sim/tx_desc_checker_props.sv
module tx_desc_checker
   import tx_descriptor_legacy16_pkg::*;
(
   input wire logic mclk_i, // Clock
   input wire logic nrst_i, // Reset
   input wire logic [FORMAT_W-1:0] descriptor_format_select_i, // Format
   input wire logic disable_tx_checksum_i, // Global disable
   input wire logic auto_pad_transmit_i, // Pad control
   input wire logic last_frame_irq_gate_i, // Irq gate
   input wire logic [ADDR_W-1:0] desc_addr_i, // Descriptor
   input wire logic desc_next_o, // Advance
   input wire logic mem_req_o, // Request
   input wire logic mem_we_o, // Write
   input wire logic [ADDR_W-1:0] mem_addr_o, // Address
   input wire logic [WORD_W-1:0] mem_wdata_o, // Write data
   input wire logic mem_ack_i, // Ack
   input wire logic [BYTE_W-1:0] tx_data_o, // Byte
   input wire logic tx_last_o, // Last
   input wire logic tx_valid_o, // Valid
   input wire logic tx_ready_i, // Ready
   input wire logic fcs_enable_o, // Checksum
   input wire logic frame_done_o, // Done
   input wire logic tx_done_irq_flag_o // Irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_wait;
      mem_req_o && !mem_ack_i;
   endsequence
   sequence s_wb_ack;
      mem_req_o && mem_we_o && mem_ack_i;
   endsequence
   a_req_hold: assert property (s_wait |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
      else $error("request changed before ack");
   a_own_clear: assert property (mem_req_o && mem_we_o |-> !mem_wdata_o[OWN_BIT])
      else $error("writeback keeps ownership");
   a_wb_place: assert property (mem_req_o && mem_we_o |-> mem_addr_o == desc_addr_i + OFS_FLAGS)
      else $error("write outside flags word");
   a_spare_skip: assert property (mem_req_o |-> mem_addr_o != desc_addr_i + OFS_SPARE)
      else $error("spare word accessed");
   a_legacy_only: assert property ($rose(mem_req_o) |-> descriptor_format_select_i == FORMAT_LEGACY16)
      else $error("sequencer ran in other format");
   a_next_after: assert property (s_wb_ack |=> desc_next_o)
      else $error("no advance after writeback");
   a_irq_cause: assert property (tx_done_irq_flag_o |-> frame_done_o)
      else $error("done flag without frame");
   a_irq_ungated: assert property (frame_done_o && !last_frame_irq_gate_i |-> tx_done_irq_flag_o)
      else $error("done flag suppressed without gate");
   a_fcs_force: assert property (frame_done_o && !disable_tx_checksum_i |-> fcs_enable_o)
      else $error("checksum off while not disabled");
   a_fcs_pad: assert property (frame_done_o && auto_pad_transmit_i && disable_tx_checksum_i |-> !fcs_enable_o)
      else $error("append flag honoured under padding");
   a_stream_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_last_o, tx_data_o}))
      else $error("stream byte changed while stalled");
endmodule

bind tx_descriptor_legacy16 tx_desc_checker chk_i (.mclk_i, .nrst_i, .descriptor_format_select_i,
   .disable_tx_checksum_i, .auto_pad_transmit_i, .last_frame_irq_gate_i, .desc_addr_i, .desc_next_o,
   .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .tx_data_o, .tx_last_o, .tx_valid_o,
   .tx_ready_i, .fcs_enable_o, .frame_done_o, .tx_done_irq_flag_o);

// ### sim/host_mem_model.sv
module host_mem_model
   import tx_descriptor_legacy16_pkg::*;
(
   input wire logic mclk_i, // Clock
   input wire logic req_i, // Access request
   input wire logic we_i, // Write
   input wire logic [ADDR_W-1:0] addr_i, // Byte address
   input wire logic [WORD_W-1:0] wdata_i, // Write data
   output logic [WORD_W-1:0] rdata_o, // Read data
   output logic ack_o, // Access done
   input wire logic [3:0] lat_i // Extra wait cycles
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [WORD_W-1:0] mem [0:1023];
   int cnt = 0;
   initial begin
      ack_o = 1'b0;
      rdata_o = 16'h5A5A;
   end
   // Data only valid with ack; held during wait cycles, otherwise it toggles
   always @(posedge mclk_i) begin
      #1;
      if (ack_o) begin
         ack_o = 1'b0;
         rdata_o = ~rdata_o;
         cnt = 0;
      end else if (req_i && cnt < int'(lat_i)) begin
         cnt++;
      end else if (req_i) begin
         ack_o = 1'b1;
         if (we_i) mem[{addr_i[17], addr_i[9:1]}] = wdata_i;
         rdata_o = mem[{addr_i[17], addr_i[9:1]}];
      end else begin
         rdata_o = ~rdata_o;
      end
   end
endmodule

// ### sim/tb_tx_descriptor_legacy16.sv
module tb_tx_descriptor_legacy16;
   import tx_descriptor_legacy16_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 0, nrst_i = 0, poll_i = 0, tx_ready_i = 1;
   logic disable_tx_checksum_i = 0, auto_pad_transmit_i = 0, last_frame_irq_gate_i = 0;
   logic [FORMAT_W-1:0] descriptor_format_select_i = 8'h00;
   logic [ADDR_W-1:0] desc_addr_i = 24'h000000, mem_addr_o, tx_buffer_pointer_o;
   logic [WORD_W-1:0] mem_wdata_o, mem_rdata_i;
   logic [BYTE_W-1:0] tx_data_o;
   logic [3:0] lat = 4'h0;
   logic desc_next_o, mem_req_o, mem_we_o, mem_ack_i, tx_last_o, tx_valid_o;
   logic fcs_enable_o, frame_done_o, tx_done_irq_flag_o, skip_o, busy_o, fcs_s, irq_s;
   logic [8:0] got_q[$], exp_q[$];
   int error_cnt = 0, checked = 0, done_n = 0, skip_n = 0;
   // Row: app sel gate dis pad | fcs irq | length[4:0]
   logic [11:0] rows [6] = '{12'h061, 12'hF62, 12'hB83, 12'h125, 12'h6E4, 12'h240};

   tx_descriptor_legacy16 dut (.mclk_i, .nrst_i, .ce_i(1'b1), .enable_i(1'b1), .poll_i,
      .descriptor_format_select_i, .disable_tx_checksum_i, .auto_pad_transmit_i, .last_frame_irq_gate_i,
      .desc_addr_i, .desc_next_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i,
      .mem_ack_i, .tx_data_o, .tx_last_o, .tx_valid_o, .tx_ready_i, .fcs_enable_o, .frame_done_o,
      .tx_done_irq_flag_o, .skip_o, .busy_o, .tx_buffer_pointer_o);
   host_mem_model u_mem (.mclk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i), .lat_i(lat));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      if (frame_done_o === 1'b1) begin
         done_n++;
         fcs_s = fcs_enable_o;
         irq_s = tx_done_irq_flag_o;
      end
      if (skip_o === 1'b1) skip_n++;
      if (desc_next_o === 1'b1) desc_addr_i <= desc_addr_i + 24'h000008;
      if (tx_valid_o === 1'b1 && tx_ready_i) got_q.push_back({tx_last_o, tx_data_o});
   end

   task tick;
      @(posedge mclk_i);
      #1;
   endtask

   task pulse;
      poll_i = 1'b1;
      tick();
      poll_i = 1'b0;
   endtask

   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   function int idx(input logic [23:0] a);
      return int'({a[17], a[9:1]});
   endfunction

   // Buffer first, ownership word last
   task put(input logic [23:0] d, input logic [23:0] b, input int n, input logic [7:0] f);
      logic [23:0] a;
      u_mem.mem[idx(d)] = b[15:0];
      u_mem.mem[idx(d + 24'h000004)] = 16'(-n);
      u_mem.mem[idx(d + 24'h000006)] = 16'hFFFF;
      u_mem.mem[idx(d + 24'h000002)] = {f, b[23:16]};
      for (int j = 0; j < n; j++) begin
         a = b + 24'(j);
         exp_q.push_back({f[0] && j == n - 1, a[7:0] ^ 8'hC3});
      end
   endtask

   task wrap_up;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task wait_done(input int n);
      for (int k = 0; k < 3000 && done_n < n; k++) tick();
      if (done_n < n) begin
         error_cnt++;
         $display("MISMATCH frame_done expected %0d seen %0d", n, done_n);
         wrap_up();
      end
   endtask

   task chk_stream;
      chk("byte_count", 24'(exp_q.size()), 24'(got_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0) chk("byte", 24'(exp_q.pop_front()), 24'(got_q.pop_front()));
      exp_q.delete();
      got_q.delete();
   endtask

   initial begin
      logic [11:0] r;
      logic [23:0] d, b;
      logic [7:0] f;
      int n0, busy_n;
      for (int k = 0; k < 1024; k++) u_mem.mem[k] = (k < 512) ? 16'h0000 : {8'(2 * k + 1) ^ 8'hC3, 8'(2 * k) ^ 8'hC3};
      repeat (5) tick();
      chk("req_rst", 24'h000000, 24'({mem_req_o, busy_o, tx_valid_o, frame_done_o}));
      tick();
      nrst_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         d = desc_addr_i;
         b = 24'h3A0401 + 24'(i * 64);
         f = {2'b11, r[11], r[10], 4'hF};
         {last_frame_irq_gate_i, disable_tx_checksum_i, auto_pad_transmit_i} = r[9:7];
         lat = 4'(i % 3);
         put(d, b, int'(r[4:0]), f);
         n0 = done_n;
         pulse();
         wait_done(n0 + 1);
         chk("fcs", 24'(r[6]), 24'(fcs_s));
         chk("irq", 24'(r[5]), 24'(irq_s));
         chk("wb", 24'({f & 8'h7F, b[23:16]}), 24'(u_mem.mem[idx(d + 24'h000002)]));
         chk_stream();
      end
      d = desc_addr_i;
      b = 24'h3A0501;
      put(d, 24'h000000, 0, 8'hC1);
      put(d + 24'h000008, b, 2, 8'hC3);
      n0 = done_n;
      pulse();
      for (int k = 0; k < 200 && skip_n == 0; k++) tick();
      chk("skip", 24'h000001, 24'(skip_n));
      chk("skip_own", 24'h00C100, 24'(u_mem.mem[idx(d + 24'h000002)]));
      pulse();
      wait_done(n0 + 1);
      chk_stream();
      tx_ready_i = 1'b0;
      d = desc_addr_i;
      put(d, 24'h3A0700, 34, 8'hE2);
      put(d + 24'h000008, 24'h3A0781, 3, 8'hE1);
      n0 = done_n;
      pulse();
      // Long enough that an unstalled frame would have completed
      repeat (300) tick();
      chk("stall_busy", 24'h000001, 24'(busy_o));
      chk("stall_frame", 24'(n0), 24'(done_n));
      chk("stall_valid", 24'h000001, 24'(tx_valid_o));
      chk("stall_ptr", 24'h3A0700 + 24'(FIFO_DEPTH), tx_buffer_pointer_o);
      tx_ready_i = 1'b1;
      wait_done(n0 + 1);
      chk("frames", 24'(n0 + 1), 24'(done_n));
      chk_stream();
      descriptor_format_select_i = 8'h01;
      d = desc_addr_i;
      put(d, 24'h3A0401, 0, 8'h4B);
      n0 = done_n;
      pulse();
      busy_n = 0;
      for (int k = 0; k < 20; k++) begin
         tick();
         if (busy_o !== 1'b0) busy_n++;
      end
      chk("busy_fmt", 24'h000000, 24'(busy_n));
      descriptor_format_select_i = 8'h00;
      repeat (20) tick();
      chk("desc_hold", d, desc_addr_i);
      chk("no_frame", 24'(n0), 24'(done_n));
      // Reset while the first buffer byte of a descriptor is being fetched
      put(d, 24'h3A0401, 20, 8'hCF);
      pulse();
      repeat (12) tick();
      nrst_i = 1'b0;
      tick();
      chk("req_rst2", 24'h000000, 24'({mem_req_o, busy_o, tx_valid_o, frame_done_o}));
      nrst_i = 1'b1;
      repeat (10) tick();
      chk("idle_rst2", 24'h000000, 24'({busy_o, tx_valid_o}));
      chk("ptr_rst2", 24'h000000, tx_buffer_pointer_o);
      wrap_up();
   end
endmodule
